/* File: rtl/interrupt_vector_priority.sv */
// Purpose: picks the winning interrupt and forms its fetch address
// Assumes: request lines synchronous to CLK, level settings static
// Notes: one registered stage; outputs follow the inputs of the previous edge
`include "intvec_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module interrupt_vector_priority
   import intvec_pkg::*;
#(
   parameter int NUM_VEC = `NUM_VECTORS
) (
   // clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // core exception and software requests
   input wire logic [3:0] CORE_EXC,
   input wire logic [3:0] SW_INT,
   // debug-unit events and their levels
   input wire logic [4:0] DEBUG_REQ,
   input wire logic [9:0] DEBUG_LEVEL,
   // peripheral requests, one per vector 16..44, and their levels
   input wire logic [28:0] PERIPH_REQ,
   input wire logic [57:0] PERIPH_LEVEL,
   // vector base, word address
   input wire logic [20:0] VECTOR_BASE_IN,
   input wire logic VECTOR_BASE_LOAD,
   // winner towards the core
   output logic IRQ_VALID,
   output logic [5:0] IRQ_VECTOR,
   output logic [1:0] IRQ_LEVEL,
   output logic IRQ_LOWEST,
   output logic [20:0] FETCH_ADDR,
   output logic [20:0] VECTOR_BASE
);

   // refuse a vector count that the fixed source map cannot serve
   if (NUM_VEC != `NUM_VECTORS) begin : g_bad_count
      $error("vector count must be 46");
   end

   // all block state
   typedef struct packed {
      logic valid;
      logic [5:0] vector;
      logic [1:0] level;
      logic lowest;
      logic [20:0] addr;
      logic [20:0] base;
   } state_type;

   state_type state; // registered state
   state_type next_state; // next value
   logic [NUM_VEC-1:0] req; // request per vector
   rank_type rank [NUM_VEC]; // rank per vector

   // maps a two-bit level field onto a rank, clamped to a range
   function automatic rank_type to_rank(input logic [1:0] lvl, input logic [1:0] lo, input logic [1:0] hi);
      logic [1:0] c;
      c = (lvl < lo) ? lo : ((lvl > hi) ? hi : lvl);
      return rank_type'({1'b0, c} + 3'h2);
   endfunction

   // gather request lines into vector positions
   always_comb begin
      req = '0;
      rank = '{default: 3'h0};
      // slots 0,1 stay empty; they hold the reset overlays
      // core exceptions and the highest software interrupt, all fixed level 3
      req[`VEC_ILLEGAL] = CORE_EXC[0];
      req[`VEC_SWI3] = SW_INT[3];
      req[`VEC_STACK_OVF] = CORE_EXC[1];
      req[`VEC_MISALIGN] = CORE_EXC[2];
      for (int i = 2; i <= 5; i++) rank[i] = 3'h5;
      // debug events: a level field of zero is lifted to level 1
      for (int i = 0; i < 5; i++) begin
         req[`VEC_DEBUG_FIRST + i] = DEBUG_REQ[i];
         rank[`VEC_DEBUG_FIRST + i] = to_rank(DEBUG_LEVEL[2*i +: 2], 2'h1, 2'h3);
      end
      // software interrupts two, one and zero sit at fixed levels
      req[`VEC_SWI2] = SW_INT[2];
      rank[`VEC_SWI2] = 3'h4;
      req[`VEC_SWI1] = SW_INT[1];
      rank[`VEC_SWI1] = 3'h3;
      req[`VEC_SWI0] = SW_INT[0];
      rank[`VEC_SWI0] = 3'h2;
      // peripherals at 16..44: power, clock, flash, ports, spi, serial, i2c, timers, conv, pwm
      for (int i = 0; i < 29; i++) begin
         req[`VEC_POWER_SENSE + i] = PERIPH_REQ[i];
         rank[`VEC_POWER_SENSE + i] = to_rank(PERIPH_LEVEL[2*i +: 2], 2'h0, 2'h2);
      end
      // unused slots can never raise, whatever their input bit shows
      req = req & ~`UNUSED_MASK;
      // the lowest software interrupt ranks under every other source
      req[`VEC_SW_LOWEST] = CORE_EXC[3];
      rank[`VEC_SW_LOWEST] = 3'h1;
   end

   // choose highest rank, ties to the lowest vector
   always_comb begin
      rank_type best;
      logic [5:0] win;
      best = 3'h0;
      win = 6'h00;
      next_state = state;
      // scan downwards so that an equal rank met later (lower vector) takes over
      for (int i = NUM_VEC - 1; i >= `VEC_FIRST_SOURCE; i--) begin
         if (req[i] && rank[i] >= best) begin
            best = rank[i];
            win = 6'(i);
         end
      end
      // base load takes effect on the fetch address one cycle later
      if (VECTOR_BASE_LOAD) next_state.base = VECTOR_BASE_IN;
      // rank zero means nothing pending
      next_state.valid = (best != 3'h0);
      next_state.vector = win;
      next_state.lowest = (best == 3'h1);
      next_state.level = (best >= 3'h2) ? 2'(best - 3'h2) : 2'h0;
      // two words per entry, 19-bit table reach kept in 21-bit bus
      next_state.addr = state.base + {14'h0000, win, 1'b0};
   end

   // state register
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         state <= '{valid: 1'b0, vector: 6'h00, level: 2'h0, lowest: 1'b0,
                    addr: 21'h00_0000, base: `VECTOR_BASE_RESET};
      end else begin
         state <= next_state;
      end
   end

   // every output is a field of the state register
   assign IRQ_VALID = state.valid;
   assign IRQ_VECTOR = state.vector;
   assign IRQ_LEVEL = state.level;
   assign IRQ_LOWEST = state.lowest;
   assign FETCH_ADDR = state.addr;
   assign VECTOR_BASE = state.base;

   // checks
   // fetch address uses the base that stood before the edge
   chk_addr_form: assert property (@(posedge CLK) disable iff (!RST_N)
      IRQ_VALID |-> FETCH_ADDR == 21'($past(VECTOR_BASE) + {IRQ_VECTOR, 1'b0}))
      else $error("fetch address not base plus twice vector");
   // base starts at zero so the reset overlays land in slots 0 and 1
   chk_base_reset: assert property (@(posedge CLK) $rose(RST_N) |-> VECTOR_BASE == 21'h0)
      else $error("vector base not zero after reset");
   // reset overlay slots are never presented
   chk_no_reserved: assert property (@(posedge CLK) disable iff (!RST_N)
      IRQ_VALID |-> IRQ_VECTOR >= 6'h02)
      else $error("reserved slot presented");
   // unused slots are never presented
   chk_unused_slot: assert property (@(posedge CLK) disable iff (!RST_N)
      IRQ_VALID |-> !(IRQ_VECTOR inside {6'h0E, 6'h0F, 6'h15, 6'h21, 6'h22}))
      else $error("unused slot presented");
   // a core exception on CORE_EXC[2:0] always brings a level 3 winner
   chk_core_level: assert property (@(posedge CLK) disable iff (!RST_N)
      $past(RST_N) && $past(|CORE_EXC[2:0]) |-> IRQ_VALID && IRQ_LEVEL == 2'h3 && IRQ_VECTOR <= 6'h0A)
      else $error("core exception not at level 3");
   // level -1 only shows when nothing else was pending
   chk_lowest_only: assert property (@(posedge CLK) disable iff (!RST_N)
      IRQ_LOWEST |-> IRQ_VECTOR == 6'h2D && $past(req[44:2] == 43'h0))
      else $error("lowest priority shown while other pending");
   // equal level: the lower vector wins
   chk_tie_low: assert property (@(posedge CLK) disable iff (!RST_N)
      $past(req[`VEC_SWI3] && req[`VEC_MISALIGN]) |-> IRQ_VECTOR <= 6'h03)
      else $error("tie not won by lowest vector");
   // fixed level of software interrupt one
   chk_swi_level: assert property (@(posedge CLK) disable iff (!RST_N)
      IRQ_VALID && IRQ_VECTOR == 6'h0C |-> IRQ_LEVEL == 2'h1)
      else $error("software interrupt one level wrong");
   // peripherals never exceed level 2
   chk_periph_cap: assert property (@(posedge CLK) disable iff (!RST_N)
      IRQ_VALID && IRQ_VECTOR >= 6'h10 && IRQ_VECTOR <= 6'h2C |-> IRQ_LEVEL <= 2'h2)
      else $error("peripheral above level 2");
   // debug events never fall below level 1
   chk_debug_floor: assert property (@(posedge CLK) disable iff (!RST_N)
      IRQ_VALID && IRQ_VECTOR inside {[6'h06:6'h0A]} |-> IRQ_LEVEL >= 2'h1)
      else $error("debug event below level 1");
   // a base inside the table reach keeps bit 20 of the fetch address clear
   chk_reach: assert property (@(posedge CLK) disable iff (!RST_N)
      $past(VECTOR_BASE[20:19]) == 2'h0 |-> FETCH_ADDR[20] == 1'b0)
      else $error("fetch address beyond table reach");

   // fixed level of software interrupt two
   chk_swi2_level: assert property (@(posedge CLK) disable iff (!RST_N)
      IRQ_VALID && IRQ_VECTOR == 6'h0B |-> IRQ_LEVEL == 2'h2)
      else $error("software interrupt two level wrong");
   // fixed level of software interrupt zero
   chk_swi0_level: assert property (@(posedge CLK) disable iff (!RST_N)
      IRQ_VALID && IRQ_VECTOR == 6'h0D |-> IRQ_LEVEL == 2'h0)
      else $error("software interrupt zero level wrong");
   // vectors 2 to 5 are always level 3
   chk_exc_vectors: assert property (@(posedge CLK) disable iff (!RST_N)
      IRQ_VALID && IRQ_VECTOR inside {[6'h02:6'h05]} |-> IRQ_LEVEL == 2'h3)
      else $error("core vector not at level 3");
   // the lowest software interrupt is flagged and reports level 0
   chk_lowest_vector: assert property (@(posedge CLK) disable iff (!RST_N)
      IRQ_VALID && IRQ_VECTOR == 6'h2D |-> IRQ_LOWEST && IRQ_LEVEL == 2'h0)
      else $error("lowest vector not flagged");
   // the lowest flag never stands without a request
   chk_lowest_valid: assert property (@(posedge CLK) disable iff (!RST_N)
      IRQ_LOWEST |-> IRQ_VALID)
      else $error("lowest flag without request");
   // no vector beyond the end of the table
   chk_vector_range: assert property (@(posedge CLK) disable iff (!RST_N)
      IRQ_VALID |-> IRQ_VECTOR <= 6'h2D)
      else $error("vector beyond table end");
   // idle outputs are clean
   chk_idle_clean: assert property (@(posedge CLK) disable iff (!RST_N)
      !IRQ_VALID |-> IRQ_VECTOR == 6'h00 && IRQ_LEVEL == 2'h0 && !IRQ_LOWEST)
      else $error("idle outputs not clean");
   // a request is shown exactly when one was pending
   chk_valid_follows: assert property (@(posedge CLK) disable iff (!RST_N)
      $past(RST_N) |-> IRQ_VALID == $past(|req))
      else $error("request presence not followed");
   // illegal instruction beats every other source
   chk_illegal_wins: assert property (@(posedge CLK) disable iff (!RST_N)
      $past(RST_N) && $past(req[`VEC_ILLEGAL]) |-> IRQ_VECTOR == 6'h02)
      else $error("illegal instruction did not win");
   // a level 3 debug event beats every peripheral
   chk_debug_wins: assert property (@(posedge CLK) disable iff (!RST_N)
      $past(RST_N) && $past(req[5:2] == 4'h0 && DEBUG_REQ[0] && DEBUG_LEVEL[1:0] == 2'h3)
      |-> IRQ_VECTOR == 6'h06 && IRQ_LEVEL == 2'h3)
      else $error("level 3 debug event did not win");
   // a peripheral level field of 3 is clamped to 2
   chk_periph_clamp: assert property (@(posedge CLK) disable iff (!RST_N)
      $past(RST_N) && $past(req[15:2] == 14'h0 && PERIPH_REQ[0] && PERIPH_LEVEL[1:0] == 2'h3)
      |-> IRQ_VECTOR == 6'h10 && IRQ_LEVEL == 2'h2)
      else $error("peripheral level not clamped");
   // flash access error at level 2 wins over later peripherals
   chk_flash_err: assert property (@(posedge CLK) disable iff (!RST_N)
      $past(RST_N) && $past(req[17:2] == 16'h0 && PERIPH_REQ[2] && PERIPH_LEVEL[5:4] == 2'h2)
      |-> IRQ_VECTOR == 6'h12)
      else $error("flash error vector wrong");
   // base load shows one cycle after the strobe
   chk_base_load: assert property (@(posedge CLK) disable iff (!RST_N)
      $past(RST_N) && $past(VECTOR_BASE_LOAD) |-> VECTOR_BASE == $past(VECTOR_BASE_IN))
      else $error("vector base not loaded");
   // a lone clock unit event lands on its vector
   chk_clock_vec: assert property (@(posedge CLK) disable iff (!RST_N)
      $past(RST_N) && $past(req == (46'h1 << 17)) |-> IRQ_VECTOR == 6'h11)
      else $error("clock unit vector wrong");
   // a lone port D event lands on its vector
   chk_port_vec: assert property (@(posedge CLK) disable iff (!RST_N)
      $past(RST_N) && $past(req == (46'h1 << 22)) |-> IRQ_VECTOR == 6'h16)
      else $error("port vector wrong");
   // a lone timer channel 0 event lands on its vector
   chk_timer_vec: assert property (@(posedge CLK) disable iff (!RST_N)
      $past(RST_N) && $past(req == (46'h1 << 36)) |-> IRQ_VECTOR == 6'h24)
      else $error("timer vector wrong");
   // a lone converter B event lands on its vector
   chk_conv_vec: assert property (@(posedge CLK) disable iff (!RST_N)
      $past(RST_N) && $past(req == (46'h1 << 41)) |-> IRQ_VECTOR == 6'h29)
      else $error("converter vector wrong");

   // main scenarios
   cov_core: cover property (@(posedge CLK) IRQ_VALID && IRQ_LEVEL == 2'h3);
   cov_periph: cover property (@(posedge CLK) IRQ_VALID && IRQ_VECTOR == 6'h2C);
   cov_lowest: cover property (@(posedge CLK) IRQ_LOWEST);
   cov_base: cover property (@(posedge CLK) VECTOR_BASE != 21'h0 && IRQ_VALID);
   cov_debug: cover property (@(posedge CLK) IRQ_VALID && IRQ_VECTOR inside {[6'h06:6'h0A]});
endmodule
`default_nettype wire

/* File: rtl/intvec_defs.svh */
// Purpose: constants for the interrupt vector priority block
// Assumes: 16-bit word program addresses, 46 vector slots
// Notes: vector numbers, unused-slot mask and reset values
`ifndef INTVEC_DEFS_SVH
`define INTVEC_DEFS_SVH
`define NUM_VECTORS 46
`define VEC_FIRST_SOURCE 2
`define VEC_ILLEGAL 6'h02
`define VEC_SWI3 6'h03
`define VEC_STACK_OVF 6'h04
`define VEC_MISALIGN 6'h05
`define VEC_DEBUG_FIRST 6'h06
`define VEC_DEBUG_LAST 6'h0A
`define VEC_SWI2 6'h0B
`define VEC_SWI1 6'h0C
`define VEC_SWI0 6'h0D
`define VEC_POWER_SENSE 6'h10
`define VEC_CLOCK_UNIT 6'h11
`define VEC_FLASH_ERR 6'h12
`define VEC_FLASH_DONE 6'h13
`define VEC_FLASH_EMPTY 6'h14
`define VEC_PORT_D 6'h16
`define VEC_SPI_RX 6'h1A
`define VEC_SPI_TX 6'h1B
`define VEC_SERIAL_FIRST 6'h1C
`define VEC_TWO_WIRE 6'h23
`define VEC_TIMER0 6'h24
`define VEC_CONV_A 6'h28
`define VEC_CONV_B 6'h29
`define VEC_CONV_LIMIT 6'h2A
`define VEC_PWM_RELOAD 6'h2B
`define VEC_PWM_FAULT 6'h2C
`define VEC_SW_LOWEST 6'h2D
`define UNUSED_MASK 46'h0006_0020_C000
`define TARGET_BITS 19
`define VECTOR_BASE_RESET 21'h00_0000
`define WORDS_PER_ENTRY_SHIFT 1
`endif

/* File: rtl/intvec_pkg.sv */
// Purpose: types for the interrupt vector priority block
// Assumes: priority encoded as five ranks, -1 the lowest
// Notes: constants live in intvec_defs.svh
package intvec_pkg;
   // rank: 0 none, 1 = level -1, 2 = level 0 ... 5 = level 3
   typedef logic [2:0] rank_type;
   typedef enum logic [1:0] {
      LVL_0 = 2'h0,
      LVL_1 = 2'h1,
      LVL_2 = 2'h2,
      LVL_3 = 2'h3
   } level_type;
endpackage

/* File: sim/core_fetch_model.sv */
// Purpose: core side that fetches the winning vector entry
// Assumes: a fetch is taken on every edge a request stands
// Notes: keeps a count and the last fetch address
`timescale 1ns/1ps
`default_nettype none
module core_fetch_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // winner from the block
   input wire logic irq_valid,
   input wire logic [20:0] fetch_addr,
   // fetch record
   output logic [15:0] fetch_count,
   output logic [20:0] last_addr
);
   // fetch the entry while a request is shown
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fetch_count <= 16'h0000;
         last_addr <= 21'h00_0000;
      end else if (irq_valid) begin
         fetch_count <= fetch_count + 16'h0001;
         last_addr <= fetch_addr;
      end
   end
endmodule
`default_nettype wire

/* File: sim/interrupt_vector_priority_tb_top.sv */
// Purpose: corner and random checks of the vector priority block
// Assumes: outputs follow the inputs of the previous edge
// Notes: ref_win works out the expected winner
`timescale 1ns/1ps
`default_nettype none
module interrupt_vector_priority_tb_top;
   // stimulus, all set at time zero
   logic clk = 1'b0, rst_n = 1'b0, ld = 1'b0;
   logic [3:0] ce = 4'h0, sw = 4'h0;
   logic [4:0] dr = 5'h00;
   logic [9:0] dl = 10'h000;
   logic [28:0] pr = 29'h0000_0000;
   logic [57:0] pl = 58'h0;
   logic [20:0] bi = 21'h00_0000, eb = 21'h00_0000, fa, vb, la;
   logic v, low;
   logic [5:0] vec;
   logic [1:0] lvl;
   logic [15:0] fc;
   logic [31:0] seed = 32'h2cd4_e886, tmp;
   int n_errors = 0, check_count = 0, cyc = 0;
   always #25 clk = ~clk;
   // cut a hang short
   always @(posedge clk) begin
      cyc++;
      if (cyc == 4000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   interrupt_vector_priority dut_u (.CLK(clk), .RST_N(rst_n), .CORE_EXC(ce), .SW_INT(sw), .DEBUG_REQ(dr),
      .DEBUG_LEVEL(dl), .PERIPH_REQ(pr), .PERIPH_LEVEL(pl), .VECTOR_BASE_IN(bi), .VECTOR_BASE_LOAD(ld),
      .IRQ_VALID(v), .IRQ_VECTOR(vec), .IRQ_LEVEL(lvl), .IRQ_LOWEST(low), .FETCH_ADDR(fa), .VECTOR_BASE(vb));
   core_fetch_model core_u (.clk(clk), .rst_n(rst_n), .irq_valid(v), .fetch_addr(fa), .fetch_count(fc),
      .last_addr(la));
   function automatic logic [31:0] nxt(input logic [31:0] s);
      nxt = {s[30:0], 1'b0} ^ (s[31] ? 32'h0400_0007 : 32'h0000_0000);
   endfunction
   // rank 5..2 for levels 3..0, 1 for the lowest; first highest rank wins
   function automatic logic [9:0] ref_win();
      int r, br, bv;
      br = 0;
      bv = 0;
      for (int i = 2; i < 46; i++) begin
         r = 0;
         if (i <= 5) r = (i == 3 ? sw[3] : ce[i == 2 ? 0 : i - 3]) ? 5 : 0;
         else if (i <= 10) r = dr[i-6] ? (dl[2*(i-6)+:2] == 2'h0 ? 3 : dl[2*(i-6)+:2] + 2) : 0;
         else if (i <= 13) r = sw[13-i] ? 15 - i : 0;
         else if (i == 45) r = ce[3] ? 1 : 0;
         else if (i >= 16 && i != 21 && i != 33 && i != 34)
            r = pr[i-16] ? (pl[2*(i-16)+:2] == 2'h3 ? 4 : pl[2*(i-16)+:2] + 2) : 0;
         if (r > br) begin
            br = r;
            bv = i;
         end
      end
      ref_win = {br != 0, 6'(bv), br < 2 ? 2'h0 : 2'(br - 2), br == 1};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one edge later, compare with the inputs just driven
   task automatic chk();
      logic [9:0] w;
      @(posedge clk);
      #1;
      w = ref_win();
      check(v, w[9]);
      if (w[9]) check({vec, lvl, low, fa}, {w[8:0], eb + {14'h0, w[8:3], 1'b0}});
      if (ld) eb = bi;
      check(vb, eb);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      chk();
      $display("reset test done");
      @(posedge clk); sw <= 4'h4; pr <= 29'h1fff_ffff; pl <= {29{2'h2}}; chk();
      @(posedge clk); sw <= 4'h0; pr <= 29'h0006_0020; ce <= 4'h8; chk();
      @(posedge clk); ld <= 1'b1; bi <= 21'h1f_ffff; ce <= 4'h4; chk();
      @(posedge clk); ld <= 1'b0; chk();
      for (int i = 0; i < 29; i++) begin
         @(posedge clk); ce <= 4'h0; pr <= 29'h1 << i; pl <= {29{2'(i)}}; chk();
      end
      $display("corner test done");
      repeat (600) begin
         @(posedge clk);
         seed = nxt(seed); ce <= seed[3:0] & seed[7:4] & seed[11:8]; sw <= seed[15:12] & seed[19:16];
         dr <= seed[24:20] & seed[29:25]; ld <= seed[31:30] == 2'h3;
         seed = nxt(seed); dl <= seed[9:0]; bi <= seed[30:10];
         seed = nxt(seed); pl[31:0] <= seed; tmp = seed;
         seed = nxt(seed); pl[57:32] <= seed[25:0]; pr <= tmp[28:0] & seed[28:0];
         chk();
      end
      $display("random test done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
